// File: shdp_byte_if.sv
`timescale 1ns/10ps

interface shdp_byte_if;
	logic       byte_valid;
	logic [7:0] byte_data;
	logic       wrq_fall;
	logic       selected;

	modport producer
	(
		output byte_valid,
		output byte_data,
		output wrq_fall,
		output selected
	);

	modport consumer
	(
		input byte_valid,
		input byte_data,
		input wrq_fall,
		input selected
	);
endinterface

// File: shdp_host.sv
`timescale 1ns/10ps

module shdp_host
(
	input  wire logic clk_sys,
	input  wire logic write_ready_flag,
	output logic      sclk,
	output logic      si,
	output logic      cs_n,
	output logic      write_request_n
);
	initial
	begin
		sclk            = 1'b1;
		si              = 1'b1;
		cs_n            = 1'b1;
		write_request_n = 1'b1;
	end

	task automatic wait_ready();
		int n;
		for (n = 0; n < 4000 && write_ready_flag !== 1'b1; n++)
			@(posedge clk_sys);
	endtask

	task automatic new_cmd();
		wait_ready();
		@(posedge clk_sys);
		#1;
		cs_n            = 1'b0;
		write_request_n = 1'b1;
		repeat (4) @(posedge clk_sys);
		#1;
		write_request_n = 1'b0;
		repeat (4) @(posedge clk_sys);
	endtask

	task automatic deselect();
		@(posedge clk_sys);
		#1;
		cs_n = 1'b1;
	endtask

	// Data changes on the fall, device samples on the rise
	task automatic send_byte(input logic [7:0] b);
		wait_ready();
		for (int i = 7; i >= 0; i--)
		begin
			@(posedge clk_sys);
			#1;
			sclk = 1'b0;
			si   = b[i];
			repeat (8) @(posedge clk_sys);
			#1;
			sclk = 1'b1;
			repeat (7) @(posedge clk_sys);
		end
		@(posedge clk_sys);
		#1;
		si = ~b[0];
	endtask
endmodule

// File: shdp_pkg.sv
package shdp_pkg;

	// ----------------------------------------------------------------
	// Command codes
	// ----------------------------------------------------------------
	localparam logic [7:0] PROGRAM_MEM_WRITE_CMD   = 8'hC0;
	localparam logic [7:0] JUMP_CODE_WRITE_CMD     = 8'hC4;
	localparam logic [7:0] COEF_WRITE_RESET_CMD    = 8'hA0;
	localparam logic [7:0] COEF_WRITE_RUN_CMD      = 8'hA4;
	localparam logic [7:0] OFFSET_WRITE_RESET_CMD  = 8'h90;
	localparam logic [7:0] OFFSET_WRITE_RUN_CMD    = 8'h94;
	localparam logic [7:0] REWRITE_PREPARE_CMD     = 8'h88;
	localparam logic [7:0] MODE_WORD_WRITE_CMD     = 8'h06;

	// ----------------------------------------------------------------
	// Set layout: address and data bytes per command
	// ----------------------------------------------------------------
	localparam logic [1:0] PROG_ADDR_BYTES  = 2'h2;
	localparam logic [1:0] RAM_ADDR_BYTES   = 2'h1;
	localparam logic [2:0] PROG_DATA_BYTES  = 3'h4;
	localparam logic [2:0] RAM_DATA_BYTES   = 3'h2;
	localparam logic [2:0] MODE_DATA_BYTES  = 3'h3;
	localparam logic [2:0] JUMP_DATA_BYTES  = 3'h1;
	localparam int         BITS_PER_BYTE    = 8;

	// ----------------------------------------------------------------
	// Timing, sizes and reset values
	// ----------------------------------------------------------------
	localparam int          CLK_PERIOD_NS     = 10;
	localparam int          WRQ_AFTER_SAMPLE_RATE_CLOCK_NS = 150;
	localparam int          WRQ_AFTER_SAMPLE_RATE_CLOCK_CYCLES =
		(WRQ_AFTER_SAMPLE_RATE_CLOCK_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
	localparam logic [1:0]  WRITE_READY_FLAG_LOW_CYCLES   = 2'h2;
	localparam int          REWRITE_DEPTH     = 16;
	localparam logic [23:0] MODE_WORD_RESET   = 24'h000004;
	localparam logic [7:0]  JUMP_CODE_RESET   = 8'h00;

	// ----------------------------------------------------------------
	// Types
	// ----------------------------------------------------------------
	typedef enum logic [3:0]
	{
		OP_NONE     = 4'h0,
		OP_PROG     = 4'h1,
		OP_COEF     = 4'h2,
		OP_OFFS     = 4'h3,
		OP_COEF_RUN = 4'h4,
		OP_OFFS_RUN = 4'h5,
		OP_PREP     = 4'h6,
		OP_JUMP     = 4'h7,
		OP_MODE     = 4'h8
	} shdp_op_t;

	typedef enum logic [2:0]
	{
		S_CMD    = 3'h0,
		S_ADDR   = 3'h1,
		S_DATA   = 3'h3,
		S_BUSY   = 3'h2,
		S_SAMPLE_RATE_CLOCK   = 3'h6,
		S_REWR   = 3'h7,
		S_IGNORE = 3'h4
	} shdp_state_t;

endpackage

// File: shdp_port.sv
// Functional notes
// [R1] Seven host pins: serial in/out, shift clock, ready, select, request, data-ready.
// [R2] Every byte shifts most significant bit first.
// [R3] An 8-bit command byte precedes operands and selects the operation.
// [R4] Code C0 writes program memory, only while processor held in reset.
// [R5] Code C4 writes the jump-condition code in reset or run state.
// [R6] Coefficient writes use A0 in reset state, A4 in run state.
// [R7] Offset writes use 90 in reset state, 94 in run state.
// [R8] Code 88 prepares a run-state rewrite by filling the rewrite buffer.
// [R9] Code 06 writes the 24-bit mode word, reset state only.
// [R10] Program set: command, two address bytes (bit 8 in first), four data bytes.
// [R11] Ready drops after a program set, rises when that write completes.
// [R12] Consecutive addresses send only data; the device advances the address.
// [R13] Host drops write-request before command, address and data of a new address.
// [R14] Coefficient set: command, 8-bit address, data upper then lower byte.
// [R15] Ready low after coefficient or offset set until the write completes.
// [R16] Offset set: command, address byte with zero top bit, two data bytes.
// [R17] Up to 16 buffered words, rewritten at successive addresses by run command.
// [R18] Jump-condition set: command then one 8-bit condition code.
// [R19] Received condition code loads on the sample-rate clock rising edge.
// [R20] Jump taken when any code bit matches a set condition-field bit.
// [R21] Ready low after jump set until the condition register update.
// [R22] In reset state host raises request 150 ns after first sample-clock rise.
// [R23] Select low for transfers; high floats serial out and ready, ignores input.
// [R24] Ready low interval lasts about two system clock cycles.
// [R25] Serial input sampled on shift clock rising edge, eight edges per byte.
`timescale 1ns/10ps

module shdp_port
	import shdp_pkg::*;
#(
	parameter int DEPTH = REWRITE_DEPTH
)
(
	input  wire logic        clk_sys,
	input  wire logic        reset_n,
	input  wire logic        cs_n,
	input  wire logic        sclk,
	input  wire logic        si,
	input  wire logic        write_request_n,
	input  wire logic        sample_rate_clock,
	input  wire logic        proc_reset_n,
	input  wire logic [7:0]  jump_condition_field,
	output logic             so,
	output logic             so_oe,
	output logic             write_ready_flag,
	output logic             write_ready_oe,
	output logic             readback_ready,
	output logic             program_mem_we,
	output logic             coef_mem_we,
	output logic             offset_mem_we,
	output logic [8:0]       mem_addr,
	output logic [31:0]      mem_data,
	output logic [23:0]      mode_word,
	output logic [7:0]       jump_code,
	output logic             jump_taken
);

	localparam int IDX_W = $clog2(DEPTH + 1);

	shdp_byte_if byte_bus ();

	shdp_state_t      state;
	shdp_op_t         op;
	logic [1:0]       addr_left;
	logic [2:0]       data_left;
	logic [8:0]       addr;
	logic [23:0]      data_acc;
	logic [1:0]       busy_cnt;
	logic [7:0]       jump_pending;
	logic [IDX_W-1:0] buf_count;
	logic [IDX_W-1:0] rew_idx;
	logic [15:0]      rw_buf [DEPTH];
	logic [2:0]       sample_rate_clock_s;
	logic [1:0]       run_s;

	// ----------------------------------------------------------------
	// Serial byte receiver
	// ----------------------------------------------------------------
	shdp_shifter u_shifter
	(
		.clk_sys         (clk_sys),
		.reset_n         (reset_n),
		.sclk            (sclk),
		.si              (si),
		.cs_n            (cs_n),
		.write_request_n (write_request_n),
		.bus             (byte_bus.producer)
	);

	// ----------------------------------------------------------------
	// Sample-rate clock and processor state synchronisers
	// ----------------------------------------------------------------
	always_ff @(posedge clk_sys or negedge reset_n)
	begin
		if (!reset_n)
		begin
			sample_rate_clock_s <= 3'h0;
			run_s  <= 2'h0;
		end
		else
		begin
			sample_rate_clock_s <= {sample_rate_clock_s[1:0], sample_rate_clock};
			run_s  <= {run_s[0], proc_reset_n};
		end
	end

	// ----------------------------------------------------------------
	// Command decode
	// ----------------------------------------------------------------
	wire       sample_rate_clock_rise = sample_rate_clock_s[1] & ~sample_rate_clock_s[2];
	wire       run       = run_s[1];
	wire       got_byte  = byte_bus.byte_valid;
	wire [7:0] rx        = byte_bus.byte_data;
	wire       restart   = byte_bus.wrq_fall;

	wire is_prog     = (rx == PROGRAM_MEM_WRITE_CMD)  & ~run;  // [R4]
	wire is_jump     = (rx == JUMP_CODE_WRITE_CMD);            // [R5]
	wire is_coef     = (rx == COEF_WRITE_RESET_CMD)   & ~run;  // [R6]
	wire is_coef_run = (rx == COEF_WRITE_RUN_CMD)     &  run;  // [R6]
	wire is_offs     = (rx == OFFSET_WRITE_RESET_CMD) & ~run;  // [R7]
	wire is_offs_run = (rx == OFFSET_WRITE_RUN_CMD)   &  run;  // [R7]
	wire is_prep     = (rx == REWRITE_PREPARE_CMD)    &  run;  // [R8]
	wire is_mode     = (rx == MODE_WORD_WRITE_CMD)    & ~run;  // [R9]

	wire shdp_op_t cmd_op =                                    // [R3]
		is_prog     ? OP_PROG     :
		is_jump     ? OP_JUMP     :
		is_coef     ? OP_COEF     :
		is_coef_run ? OP_COEF_RUN :
		is_offs     ? OP_OFFS     :
		is_offs_run ? OP_OFFS_RUN :
		is_prep     ? OP_PREP     :
		is_mode     ? OP_MODE     : OP_NONE;

	wire [1:0] cmd_addr_bytes =
		(cmd_op == OP_PROG) ? PROG_ADDR_BYTES :             // [R10]
		(cmd_op == OP_COEF || cmd_op == OP_OFFS ||
		 cmd_op == OP_COEF_RUN || cmd_op == OP_OFFS_RUN) ?
		RAM_ADDR_BYTES : 2'h0;                              // [R14] [R16]

	function automatic logic [2:0] data_bytes(input shdp_op_t o);
		case (o)
			OP_PROG: data_bytes = PROG_DATA_BYTES;          // [R10]
			OP_MODE: data_bytes = MODE_DATA_BYTES;
			OP_JUMP: data_bytes = JUMP_DATA_BYTES;          // [R18]
			default: data_bytes = RAM_DATA_BYTES;           // [R14] [R16]
		endcase
	endfunction

	wire [31:0] next_data  = {data_acc, rx};
	wire [8:0]  next_addr  = {addr[0] & (op == OP_PROG), rx};
	wire        last_data  = (data_left == 3'h1);
	wire        last_addr  = (addr_left == 2'h1);
	wire        run_op     = (op == OP_COEF_RUN) || (op == OP_OFFS_RUN);
	wire        buf_room   = (buf_count < IDX_W'(DEPTH));
	wire        rew_last   = (rew_idx == buf_count - IDX_W'(1));
	wire        may_start  = (state == S_CMD) || (state == S_ADDR) ||
	                         (state == S_DATA) || (state == S_IGNORE);
	wire        set_done   = (state == S_DATA) && got_byte && last_data;
	wire        single_set = (op == OP_PROG) || (op == OP_COEF) ||
	                         (op == OP_OFFS) || (op == OP_MODE);

	// ----------------------------------------------------------------
	// Transfer sequencer
	// ----------------------------------------------------------------
	always_ff @(posedge clk_sys or negedge reset_n)
	begin
		if (!reset_n)
		begin
			state     <= S_CMD;
			op        <= OP_NONE;
			addr_left <= 2'h0;
			data_left <= 3'h0;
			busy_cnt  <= 2'h0;
			rew_idx   <= '0;
		end
		else if (restart && may_start)                      // [R13]
		begin
			state <= S_CMD;
		end
		else
		begin
			case (state)
				S_CMD:
					if (got_byte)
					begin
						op        <= cmd_op;                // [R3]
						addr_left <= cmd_addr_bytes;
						data_left <= data_bytes(cmd_op);
						if (cmd_op == OP_NONE)
							state <= S_IGNORE;
						else if (cmd_addr_bytes != 2'h0)
							state <= S_ADDR;
						else
							state <= S_DATA;
					end
				S_ADDR:
					if (got_byte)
					begin
						addr_left <= addr_left - 2'h1;
						if (last_addr)
							state <= run_op ? S_SAMPLE_RATE_CLOCK : S_DATA; // [R17]
					end
				S_DATA:
					if (got_byte)
					begin
						data_left <= last_data ? data_bytes(op) :
						             data_left - 3'h1;
						if (last_data && single_set)
						begin
							state    <= S_BUSY;             // [R11] [R15]
							busy_cnt <= WRITE_READY_FLAG_LOW_CYCLES - 2'h1; // [R24]
						end
						else if (last_data && op == OP_JUMP)
							state <= S_SAMPLE_RATE_CLOCK;                // [R21]
					end
				S_BUSY:
					if (busy_cnt == 2'h0)
						state <= S_DATA;                    // [R12]
					else
						busy_cnt <= busy_cnt - 2'h1;
				S_SAMPLE_RATE_CLOCK:
					if (sample_rate_clock_rise)                          // [R19]
					begin
						rew_idx <= '0;
						if (op == OP_JUMP || buf_count == '0)
							state <= (op == OP_JUMP) ? S_DATA : S_CMD;
						else
							state <= S_REWR;                // [R17]
					end
				S_REWR:
				begin
					rew_idx <= rew_idx + IDX_W'(1);
					if (rew_last)
						state <= S_CMD;
				end
				S_IGNORE:
					state <= S_IGNORE;
				default:
					state <= S_CMD;
			endcase
		end
	end

	// ----------------------------------------------------------------
	// Address and data accumulation
	// ----------------------------------------------------------------
	always_ff @(posedge clk_sys or negedge reset_n)
	begin
		if (!reset_n)
		begin
			addr     <= 9'h000;
			data_acc <= 24'h000000;
		end
		else if (state == S_ADDR && got_byte)
			addr <= next_addr;                              // [R10] [R14]
		else if (state == S_DATA && got_byte)
			data_acc <= next_data[23:0];                    // [R2]
		else if (state == S_BUSY && busy_cnt == 2'h0)
			addr <= addr + 9'h001;                          // [R12]
	end

	// ----------------------------------------------------------------
	// Memory write port
	// ----------------------------------------------------------------
	wire        rew_coef = (op == OP_COEF_RUN);
	wire        rew_we   = (state == S_REWR);
	wire [8:0]  rew_addr = addr + 9'(rew_idx);

	always_ff @(posedge clk_sys or negedge reset_n)
	begin
		if (!reset_n)
		begin
			program_mem_we <= 1'b0;
			coef_mem_we    <= 1'b0;
			offset_mem_we  <= 1'b0;
			mem_addr       <= 9'h000;
			mem_data       <= 32'h00000000;
		end
		else
		begin
			program_mem_we <= set_done && (op == OP_PROG);  // [R11]
			coef_mem_we    <= (set_done && op == OP_COEF) ||
			                  (rew_we && rew_coef);         // [R15] [R17]
			offset_mem_we  <= (set_done && op == OP_OFFS) ||
			                  (rew_we && !rew_coef);        // [R15] [R17]
			if (set_done)
			begin
				mem_addr <= addr;
				mem_data <= (op == OP_PROG) ? next_data :
				            {16'h0000, next_data[15:0]};
			end
			else if (rew_we)
			begin
				mem_addr <= rew_addr;                       // [R17]
				mem_data <= {16'h0000, rw_buf[rew_idx[$clog2(DEPTH)-1:0]]};
			end
		end
	end

	// ----------------------------------------------------------------
	// Rewrite buffer
	// ----------------------------------------------------------------
	wire buf_load = set_done && (op == OP_PREP) && buf_room;

	always_ff @(posedge clk_sys or negedge reset_n)
	begin
		if (!reset_n)
			buf_count <= '0;
		else if (state == S_REWR && rew_last)
			buf_count <= '0;
		else if (buf_load)
			buf_count <= buf_count + IDX_W'(1);             // [R17]
	end

	genvar gi;
	generate
		for (gi = 0; gi < DEPTH; gi++)
		begin : g_buf
			always_ff @(posedge clk_sys or negedge reset_n)
			begin
				if (!reset_n)
					rw_buf[gi] <= 16'h0000;
				else if (buf_load && buf_count == IDX_W'(gi))
					rw_buf[gi] <= next_data[15:0];          // [R8]
			end
		end
	endgenerate

	// ----------------------------------------------------------------
	// Mode word and jump condition
	// ----------------------------------------------------------------
	always_ff @(posedge clk_sys or negedge reset_n)
	begin
		if (!reset_n)
		begin
			mode_word    <= MODE_WORD_RESET;
			jump_pending <= JUMP_CODE_RESET;
			jump_code    <= JUMP_CODE_RESET;
		end
		else
		begin
			if (set_done && op == OP_MODE)
				mode_word <= next_data[23:0];               // [R9]
			if (set_done && op == OP_JUMP)
				jump_pending <= rx;                         // [R18]
			if (state == S_SAMPLE_RATE_CLOCK && sample_rate_clock_rise && op == OP_JUMP)
				jump_code <= jump_pending;                  // [R19]
		end
	end

	assign jump_taken = |(jump_code & jump_condition_field); // [R20]

	// ----------------------------------------------------------------
	// Host-facing outputs
	// ----------------------------------------------------------------
	assign write_ready_flag = ~((state == S_BUSY) ||        // [R11] [R15]
	                            (state == S_SAMPLE_RATE_CLOCK) ||        // [R21]
	                            (state == S_REWR));         // [R17]
	assign write_ready_oe   = byte_bus.selected;            // [R23] [R1]
	assign so               = 1'b0;
	assign so_oe            = byte_bus.selected;            // [R23]
	assign readback_ready   = 1'b0;

endmodule

// File: shdp_port_assertions.sv
`timescale 1ns/10ps

module shdp_port_assertions
	import shdp_pkg::*;
#(
	parameter int DEPTH = REWRITE_DEPTH
)
(
	input  wire logic        clk_sys,
	input  wire logic        reset_n,
	input  wire logic        cs_n,
	input  wire logic        proc_reset_n,
	input  wire logic [7:0]  jump_condition_field,
	input  wire logic        so,
	input  wire logic        so_oe,
	input  wire logic        write_ready_flag,
	input  wire logic        write_ready_oe,
	input  wire logic        readback_ready,
	input  wire logic        program_mem_we,
	input  wire logic        coef_mem_we,
	input  wire logic        offset_mem_we,
	input  wire logic [8:0]  mem_addr,
	input  wire logic [23:0] mode_word,
	input  wire logic [7:0]  jump_code,
	input  wire logic        jump_taken
);
	default clocking cb @(posedge clk_sys);
	endclocking
	default disable iff (!reset_n);

	// ------------------------------------------------------------
	// Sequences
	// ------------------------------------------------------------
	sequence ready_gap;
		!write_ready_flag ##1 !write_ready_flag ##1 write_ready_flag;
	endsequence

	sequence burst_step;
		(coef_mem_we ##1 coef_mem_we) or (offset_mem_we ##1 offset_mem_we);
	endsequence

	chk_prog_ready: assert property (program_mem_we |-> ready_gap)
		else $error("ready gap after program write wrong");
	chk_ram_ready: assert property ((coef_mem_we || offset_mem_we) && !proc_reset_n |-> ready_gap)
		else $error("ready gap after memory write wrong");
	chk_rewrite_step: assert property (burst_step |-> mem_addr == $past(mem_addr) + 9'h001)
		else $error("rewrite address did not advance");
	chk_write_onehot: assert property ($onehot0({program_mem_we, coef_mem_we, offset_mem_we}))
		else $error("two write strobes at once");
	chk_prog_state: assert property (program_mem_we |-> !proc_reset_n)
		else $error("program write outside reset state");
	chk_mode_state: assert property ($changed(mode_word) |-> !proc_reset_n)
		else $error("mode word changed in run state");
	chk_jump_load: assert property ($changed(jump_code) |-> !$past(write_ready_flag, 2) || !$past(write_ready_flag, 3))
		else $error("jump code changed while ready high");
	chk_jump_taken: assert property (jump_taken == |(jump_code & jump_condition_field))
		else $error("jump decision wrong");
	chk_deselect_float: assert property (cs_n [*4] |-> !so_oe && !write_ready_oe)
		else $error("pins driven while deselected");
	chk_select_drive: assert property (!cs_n [*4] |-> so_oe && write_ready_oe)
		else $error("pins not driven while selected");
	chk_pins_idle: assert property (readback_ready == 1'b0 && so == 1'b0)
		else $error("readback pins active");
endmodule

// File: shdp_shifter.sv
`timescale 1ns/10ps

module shdp_shifter
	import shdp_pkg::*;
(
	input  wire logic      clk_sys,
	input  wire logic      reset_n,
	input  wire logic      sclk,
	input  wire logic      si,
	input  wire logic      cs_n,
	input  wire logic      write_request_n,
	shdp_byte_if.producer  bus
);

	logic [2:0] sclk_s;
	logic [1:0] si_s;
	logic [1:0] cs_s;
	logic [2:0] wrq_s;
	logic [6:0] shreg;
	logic [2:0] bit_cnt;
	logic       byte_valid;
	logic [7:0] byte_data;

	// ----------------------------------------------------------------
	// Pin synchronisers
	// ----------------------------------------------------------------
	always_ff @(posedge clk_sys or negedge reset_n)
	begin
		if (!reset_n)
		begin
			sclk_s <= 3'h7;
			si_s   <= 2'h0;
			cs_s   <= 2'h3;
			wrq_s  <= 3'h7;
		end
		else
		begin
			sclk_s <= {sclk_s[1:0], sclk};
			si_s   <= {si_s[0], si};
			cs_s   <= {cs_s[0], cs_n};
			wrq_s  <= {wrq_s[1:0], write_request_n};
		end
	end

	wire sclk_rise = sclk_s[1] & ~sclk_s[2];    // [R25]
	wire selected  = ~cs_s[1];                  // [R23]
	wire wrq_fall  = wrq_s[2] & ~wrq_s[1];
	wire last_bit  = (bit_cnt == 3'(BITS_PER_BYTE - 1));
	wire [7:0] full_byte = {shreg, si_s[1]};

	// ----------------------------------------------------------------
	// Byte assembly, MSB first
	// ----------------------------------------------------------------
	always_ff @(posedge clk_sys or negedge reset_n)
	begin
		if (!reset_n)
		begin
			shreg      <= 7'h00;
			bit_cnt    <= 3'h0;
			byte_valid <= 1'b0;
			byte_data  <= 8'h00;
		end
		else
		begin
			byte_valid <= 1'b0;
			if (!selected || wrq_fall)               // [R23]
				bit_cnt <= 3'h0;
			else if (sclk_rise)                      // [R25]
			begin
				shreg   <= full_byte[6:0];           // [R2]
				bit_cnt <= bit_cnt + 3'h1;
				if (last_bit)
				begin
					byte_valid <= 1'b1;
					byte_data  <= full_byte;         // [R2]
				end
			end
		end
	end

	assign bus.byte_valid = byte_valid;
	assign bus.byte_data  = byte_data;
	assign bus.wrq_fall   = wrq_fall;
	assign bus.selected   = selected;

endmodule

// File: testbench.sv
`timescale 1ns/10ps

module testbench
	import shdp_pkg::*;
;
	localparam int DEPTH_TB = 4;
	localparam int TIMEOUT  = 60000;

	logic        clk_sys;
	logic        reset_n;
	logic        sample_rate_clock;
	logic        proc_reset_n;
	logic [7:0]  jump_condition_field;
	logic        sclk;
	logic        si;
	logic        cs_n;
	logic        write_request_n;
	logic        so;
	logic        so_oe;
	logic        write_ready_flag;
	logic        write_ready_oe;
	logic        readback_ready;
	logic        program_mem_we;
	logic        coef_mem_we;
	logic        offset_mem_we;
	logic [8:0]  mem_addr;
	logic [31:0] mem_data;
	logic [23:0] mode_word;
	logic [7:0]  jump_code;
	logic        jump_taken;
	logic [7:0]  cmd;
	logic [7:0]  jv;
	logic [8:0]  a;
	logic [31:0] d;
	logic [23:0] m;
	logic [42:0] exp_q[$];
	wire  [42:0] seen_w;
	int          k;
	int          w;
	int          nw;
	int          cyc;
	int          err_total;
	int          num_checks;

	shdp_port #(.DEPTH(DEPTH_TB)) uut
	(
		.clk_sys(clk_sys), .reset_n(reset_n), .cs_n(cs_n), .sclk(sclk),
		.si(si), .write_request_n(write_request_n),
		.sample_rate_clock(sample_rate_clock), .proc_reset_n(proc_reset_n),
		.jump_condition_field(jump_condition_field), .so(so), .so_oe(so_oe),
		.write_ready_flag(write_ready_flag), .write_ready_oe(write_ready_oe),
		.readback_ready(readback_ready), .program_mem_we(program_mem_we),
		.coef_mem_we(coef_mem_we), .offset_mem_we(offset_mem_we),
		.mem_addr(mem_addr), .mem_data(mem_data), .mode_word(mode_word),
		.jump_code(jump_code), .jump_taken(jump_taken)
	);

	shdp_host host
	(
		.clk_sys(clk_sys), .write_ready_flag(write_ready_flag), .sclk(sclk),
		.si(si), .cs_n(cs_n), .write_request_n(write_request_n)
	);

	assign seen_w = {coef_mem_we | offset_mem_we,
		program_mem_we | offset_mem_we, mem_addr, mem_data};

	initial
	begin
		clk_sys = 1'b0;
		forever #5 clk_sys = ~clk_sys;
	end

	initial
	begin
		sample_rate_clock = 1'b0;
		#3;
		forever #1000 sample_rate_clock = ~sample_rate_clock;
	end

	task automatic check(input string name, input logic [42:0] seen,
		input logic [42:0] exp);
		num_checks++;
		if (seen !== exp)
		begin
			err_total++;
			$display("Error %s expected %h seen %h", name, exp, seen);
		end
	endtask

	task automatic wrap_up();
		if (err_total == 0 && num_checks > 0)
			$display("ALL TESTS PASSED");
		else
			$display("TESTS FAILED");
		$finish;
	endtask

	task automatic send_bytes(input logic [31:0] v, input int n);
		for (int i = n - 1; i >= 0; i--)
			host.send_byte(v[8 * i +: 8]);
	endtask

	task automatic do_jump(input logic [7:0] j);
		host.new_cmd();
		host.send_byte(JUMP_CODE_WRITE_CMD);
		host.send_byte(j);
		repeat (8) @(posedge clk_sys);
		host.wait_ready();
		repeat (2) @(posedge clk_sys);
		check("jump code", {35'h0, jump_code}, {35'h0, j});
		for (int n = 0; n < 4; n++)
		begin
			@(posedge clk_sys);
			#1;
			jump_condition_field = 8'($urandom);
			#1;
			check("jump taken", {42'h0, jump_taken}, {42'h0, |(j & jump_condition_field)});
		end
	endtask

	// ------------------------------------------------------------
	// Write monitor: each strobe takes the oldest expectation
	// ------------------------------------------------------------
	always @(posedge clk_sys)
		if (reset_n && (program_mem_we || coef_mem_we || offset_mem_we))
		begin
			if (exp_q.size() == 0)
				check("unexpected write", seen_w, 43'h0);
			else
				check("memory write", seen_w, exp_q.pop_front());
		end

	always @(posedge clk_sys)
	begin
		cyc <= cyc + 1;
		if (cyc == TIMEOUT)
		begin
			err_total++;
			wrap_up();
		end
	end

	initial
	begin
		reset_n              = 1'b0;
		proc_reset_n         = 1'b0;
		jump_condition_field = 8'h00;
		err_total            = 0;
		num_checks           = 0;
		cyc                  = 0;
		void'($urandom(32'hC191));
		repeat (12) @(posedge clk_sys);
		#1;
		reset_n = 1'b1;
		repeat (2) @(posedge clk_sys);
		check("mode reset", {19'h0, mode_word},
			{19'h0, MODE_WORD_RESET});
		check("jump reset", {35'h0, jump_code},
			{35'h0, JUMP_CODE_RESET});
		@(posedge sample_rate_clock);
		repeat (WRQ_AFTER_SAMPLE_RATE_CLOCK_CYCLES) @(posedge clk_sys);
		for (k = 1; k <= 3; k++)
		begin
			cmd = (k == 1) ? PROGRAM_MEM_WRITE_CMD :
				(k == 2) ? COEF_WRITE_RESET_CMD : OFFSET_WRITE_RESET_CMD;
			a = 9'($urandom);
			if (k > 1)
				a[8] = 1'b0;
			if (k == 3)
				a[7] = 1'b0;
			host.new_cmd();
			host.send_byte(cmd);
			send_bytes({23'h0, a}, (k == 1) ? 2 : 1);
			for (w = 0; w < 2; w++)
			begin
				d = $urandom;
				if (k > 1)
					d[31:16] = 16'h0;
				exp_q.push_back({2'(k), a + 9'(w), d});
				send_bytes(d, (k == 1) ? 4 : 2);
			end
		end
		m = 24'($urandom);
		host.new_cmd();
		host.send_byte(MODE_WORD_WRITE_CMD);
		send_bytes({8'h0, m}, 3);
		repeat (4) @(posedge clk_sys);
		check("mode word", {19'h0, mode_word}, {19'h0, m});
		host.new_cmd();
		host.send_byte(COEF_WRITE_RUN_CMD);
		send_bytes($urandom, 3);
		jv = 8'($urandom);
		do_jump(jv);
		@(posedge clk_sys) #1 proc_reset_n = 1'b1;
		host.new_cmd();
		host.send_byte(PROGRAM_MEM_WRITE_CMD);
		send_bytes($urandom, 4);
		host.new_cmd();
		host.send_byte(MODE_WORD_WRITE_CMD);
		send_bytes({8'h0, ~m}, 3);
		repeat (4) @(posedge clk_sys);
		check("mode kept", {19'h0, mode_word}, {19'h0, m});
		jv = 8'($urandom);
		do_jump(jv);
		for (k = 0; k < 2; k++)
		begin
			nw = k ? DEPTH_TB + 1 : 2;
			a = {2'h0, 7'($urandom)};
			host.new_cmd();
			host.send_byte(REWRITE_PREPARE_CMD);
			for (w = 0; w < nw; w++)
			begin
				d = {16'h0, 16'($urandom)};
				if (w < DEPTH_TB)
					exp_q.push_back({k ? 2'h3 : 2'h2, a + 9'(w), d});
				send_bytes(d, 2);
			end
			host.new_cmd();
			host.send_byte(k ? OFFSET_WRITE_RUN_CMD : COEF_WRITE_RUN_CMD);
			host.send_byte(a[7:0]);
		end
		host.wait_ready();
		host.deselect();
		repeat (6) @(posedge clk_sys);
		check("floated pins", {41'h0, so_oe, write_ready_oe}, 43'h0);
		send_bytes({16'h0, JUMP_CODE_WRITE_CMD, ~jv}, 2);
		repeat (300) @(posedge clk_sys);
		check("jump kept", {35'h0, jump_code}, {35'h0, jv});
		check("pending writes", 43'(exp_q.size()), 43'h0);
		wrap_up();
	end
endmodule

bind shdp_port shdp_port_assertions #(.DEPTH(DEPTH)) chk
(
	.clk_sys(clk_sys), .reset_n(reset_n), .cs_n(cs_n),
	.proc_reset_n(proc_reset_n), .jump_condition_field(jump_condition_field),
	.so(so), .so_oe(so_oe), .write_ready_flag(write_ready_flag),
	.write_ready_oe(write_ready_oe), .readback_ready(readback_ready),
	.program_mem_we(program_mem_we), .coef_mem_we(coef_mem_we),
	.offset_mem_we(offset_mem_we), .mem_addr(mem_addr),
	.mode_word(mode_word), .jump_code(jump_code), .jump_taken(jump_taken)
);
